// ---- logic/adccc_pkg.sv ----
// Package: register map, field layout and timing constants of the conversion control block
package adccc_pkg;
    // ==========================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CONVERSION_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COMPARE_TRIGGER_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h0c;
    localparam logic [7:0] ADDR_COMPARE_LEVEL = 8'h10;
    // ==========================================
    // Field positions
    localparam int CC_DONE_BIT = 7;
    localparam int CC_IRQ_EN_BIT = 6;
    localparam int CC_CONT_BIT = 5;
    localparam int CT_ACTIVE_BIT = 7;
    localparam int CT_TRIG_SEL_BIT = 6;
    localparam int CT_CMP_EN_BIT = 5;
    localparam int CT_CMP_GE_BIT = 4;
    // ==========================================
    // Channel codes and reset values
    localparam logic [4:0] CHAN_RESERVED = 5'h1c;
    localparam logic [4:0] CHAN_HIGH_REF = 5'h1d;
    localparam logic [4:0] CHAN_LOW_REF = 5'h1e;
    localparam logic [4:0] CHAN_OFF = 5'h1f;
    localparam logic [7:0] RST_CONVERSION_CONTROL = 8'h1f;
    localparam logic [7:0] RST_COMPARE_TRIGGER_CONTROL = 8'h00;
    localparam logic [9:0] RST_RESULT = 10'h000;
    // ==========================================
    // Converter stub timing
    localparam int CONV_TIME_NS = 2500;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    // ==========================================
    // Carrier types
    typedef struct packed {
        logic [9:0] result;
        logic done;
    } adccc_conv_out_type;
    typedef enum logic [2:0] {
        ADCCC_IDLE = 3'b001,
        ADCCC_CONV = 3'b010,
        ADCCC_CONT = 3'b100
    } adccc_state_type;
endpackage

// ---- logic/adccc_conv_stub.sv ----
// Converter stub: returns a result and a done pulse a fixed time after start
`timescale 1ns/10ps
module adccc_conv_stub (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [4:0] i_channel,
    input wire logic [9:0] i_sample,
    // Result
    output adccc_pkg::adccc_conv_out_type o_conv
);
    logic [7:0] count;
    logic busy;
    logic [4:0] chan;
    wire logic last = busy && (count == 8'h01);

    // ==========================================
    // Countdown, restarted by any start, reloaded but stopped by an abort without start
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= 8'h00;
            busy <= 1'b0;
            chan <= 5'h00;
            o_conv <= '0;
        end else begin
            o_conv.done <= 1'b0;
            if (i_start || i_abort) begin
                count <= 8'(adccc_pkg::CONV_CYCLES);
                busy <= i_start;
                chan <= i_channel;
            end else if (last) begin
                busy <= 1'b0;
                count <= 8'h00;
                o_conv.done <= 1'b1;
                o_conv.result <= (chan == adccc_pkg::CHAN_HIGH_REF) ? 10'h3ff :
                                 (chan == adccc_pkg::CHAN_LOW_REF) ? 10'h000 : i_sample;
            end else if (busy) begin
                count <= count - 8'h01;
            end
        end
    end
endmodule

// ---- logic/adccc_top.sv ----
// Conversion control and status of a successive-approximation converter, APB slave
// ==========================================
// Functional notes
// - Writing conversion control aborts current conversion, starts new unless channel all ones or trigger select bit 6 set.
// - Compare off: done flag bit 7 sets at every conversion end.
// - Compare on: done flag sets only when compare outcome true.
// - Done flag clears on conversion control write or low result read.
// - Interrupt asserted while done flag set and irq enable bit 6 high.
// - Continuous off: one conversion per write or hardware trigger, then idle.
// - Continuous on: back-to-back conversions after write or trigger event.
// - Channel field bits 4:0: 0-27 inputs, 1c reserved, 1d/1e references.
// - Channel all ones switches converter off, no extra conversion.
// - Single mode returns to low-power idle after completion automatically.
// - Active bit 7 of second register set on start, cleared on single-mode end or abort.
// - Trigger select bit 6: 0 software write, 1 hardware trigger input.
// - Compare enable bit 5 turns automatic compare on or off.
// - Compare direction bit 4: 0 less than, 1 greater or equal.
// - Result registers load at every completion unless compare on and false.
`timescale 1ns/10ps
module adccc_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Converter side
    input wire logic i_hw_trigger_in,
    input wire logic [9:0] i_sample,
    output logic [4:0] o_channel_select,
    output logic o_converter_on,
    output logic o_done_irq
);
    // ==========================================
    // Registers
    logic [7:0] conversion_control;
    logic [7:0] compare_trigger_control;
    logic [9:0] result;
    logic [9:0] compare_level;
    logic hw_trig_q;
    adccc_pkg::adccc_state_type state;
    adccc_pkg::adccc_state_type next_state;
    adccc_pkg::adccc_conv_out_type conv;

    // ==========================================
    // Bus decode
    wire logic access = i_psel && i_penable;
    wire logic wr = access && i_pwrite;
    wire logic rd = access && !i_pwrite;
    wire logic hit_cc = (i_paddr == adccc_pkg::ADDR_CONVERSION_CONTROL);
    wire logic hit_ct = (i_paddr == adccc_pkg::ADDR_COMPARE_TRIGGER_CONTROL);
    wire logic hit_rh = (i_paddr == adccc_pkg::ADDR_RESULT_HIGH);
    wire logic hit_rl = (i_paddr == adccc_pkg::ADDR_RESULT_LOW);
    wire logic hit_cv = (i_paddr == adccc_pkg::ADDR_COMPARE_LEVEL);
    wire logic mapped = hit_cc || hit_ct || hit_rh || hit_rl || hit_cv;
    wire logic wr_cc = wr && hit_cc;
    wire logic rd_rl = rd && hit_rl;

    // ==========================================
    // Field views
    wire logic [4:0] channel_select = conversion_control[4:0];
    wire logic continuous_enable = conversion_control[adccc_pkg::CC_CONT_BIT];
    wire logic done_irq_enable = conversion_control[adccc_pkg::CC_IRQ_EN_BIT];
    wire logic conv_done_flag = conversion_control[adccc_pkg::CC_DONE_BIT];
    wire logic trigger_select = compare_trigger_control[adccc_pkg::CT_TRIG_SEL_BIT];
    wire logic compare_enable = compare_trigger_control[adccc_pkg::CT_CMP_EN_BIT];
    wire logic compare_greater_equal = compare_trigger_control[adccc_pkg::CT_CMP_GE_BIT];
    wire logic [4:0] wr_channel = i_pwdata[4:0];
    wire logic conv_active = (state != adccc_pkg::ADCCC_IDLE);

    // ==========================================
    // Start sources
    wire logic hw_edge = i_hw_trigger_in && !hw_trig_q;
    wire logic wr_off = (wr_channel == adccc_pkg::CHAN_OFF);
    wire logic sw_start = wr_cc && !wr_off && !trigger_select;
    wire logic hw_start = trigger_select && hw_edge && (channel_select != adccc_pkg::CHAN_OFF) &&
                          (state == adccc_pkg::ADCCC_IDLE) && !wr_cc;
    wire logic start = sw_start || hw_start;
    wire logic abort = wr_cc && conv_active;
    wire logic repeat_conv = conv.done && (state == adccc_pkg::ADCCC_CONT) && !wr_cc;

    // ==========================================
    // Compare outcome
    wire logic less_than = conv.result < compare_level;
    wire logic cmp_true = compare_greater_equal ? !less_than : less_than;
    // A completion on the edge of a control write still counts: the set wins over the clear
    wire logic accept = conv.done && (!compare_enable || cmp_true);

    // Continuous bit as it will stand after this cycle's write
    function automatic logic continuous_next();
        return wr_cc ? i_pwdata[adccc_pkg::CC_CONT_BIT] : continuous_enable;
    endfunction

    // ==========================================
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            adccc_pkg::ADCCC_IDLE: begin
                if (start) begin
                    next_state = continuous_next() ? adccc_pkg::ADCCC_CONT : adccc_pkg::ADCCC_CONV;
                end
            end
            adccc_pkg::ADCCC_CONV, adccc_pkg::ADCCC_CONT: begin
                if (wr_cc) begin
                    next_state = !start ? adccc_pkg::ADCCC_IDLE :
                                 continuous_next() ? adccc_pkg::ADCCC_CONT : adccc_pkg::ADCCC_CONV;
                end else if (conv.done && state == adccc_pkg::ADCCC_CONV) begin
                    next_state = adccc_pkg::ADCCC_IDLE;
                end
            end
            default: next_state = adccc_pkg::ADCCC_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= adccc_pkg::ADCCC_IDLE;
            hw_trig_q <= 1'b0;
        end else begin
            state <= next_state;
            hw_trig_q <= i_hw_trigger_in;
        end
    end

    // ==========================================
    // Register writes; hardware set of the done flag wins over its clear
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            conversion_control <= adccc_pkg::RST_CONVERSION_CONTROL;
            compare_trigger_control <= adccc_pkg::RST_COMPARE_TRIGGER_CONTROL;
            compare_level <= adccc_pkg::RST_RESULT;
            result <= adccc_pkg::RST_RESULT;
        end else begin
            if (wr_cc) begin
                conversion_control[6:0] <= i_pwdata[6:0];
            end
            if (accept) begin
                conversion_control[adccc_pkg::CC_DONE_BIT] <= 1'b1;
                result <= conv.result;
            end else if (wr_cc || rd_rl) begin
                conversion_control[adccc_pkg::CC_DONE_BIT] <= 1'b0;
            end
            if (wr && hit_ct) begin
                compare_trigger_control <= {1'b0, i_pwdata[6:4], 4'h0};
            end
            if (wr && hit_cv) begin
                compare_level <= i_pwdata[9:0];
            end
        end
    end

    // ==========================================
    // Read data and outputs; zero wait states, unmapped address errors
    wire logic [7:0] ct_view = {conv_active, compare_trigger_control[6:0]};
    wire logic [31:0] rd_mux = hit_cc ? {24'h0, conversion_control} :
                               hit_ct ? {24'h0, ct_view} :
                               hit_rh ? {30'h0, result[9:8]} :
                               hit_rl ? {24'h0, result[7:0]} :
                               hit_cv ? {22'h0, compare_level} : 32'h0;
    assign o_prdata = rd_mux;
    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;
    assign o_channel_select = channel_select;
    assign o_converter_on = conv_active;
    assign o_done_irq = conv_done_flag && done_irq_enable;

    adccc_conv_stub u_conv (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_start(start || repeat_conv),
        .i_abort(abort),
        .i_channel(wr_cc ? wr_channel : channel_select),
        .i_sample(i_sample),
        .o_conv(conv)
    );

    // ==========================================
    // Checks
    sequence write_cc_s;
        wr_cc && !wr_off && !trigger_select;
    endsequence
    sequence flag_rise_s;
        !conv_done_flag ##1 conv_done_flag;
    endsequence
    sequence cont_done_s;
        conv.done && state == adccc_pkg::ADCCC_CONT && !wr_cc;
    endsequence
    chk_write_starts: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        write_cc_s |=> conv_active) else $error("write did not start conversion");
    chk_off_stops: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        wr_cc && wr_off |=> !conv_active) else $error("off code left converter active");
    chk_abort_drops: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        abort && !start |=> !conv_active) else $error("abort left converter active");
    chk_done_sets: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        conv.done && !compare_enable |=> conv_done_flag) else $error("done flag not set");
    chk_flag_origin: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        flag_rise_s |-> $past(accept)) else $error("done flag set without completion");
    chk_cmp_false_keep: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        conv.done && compare_enable && !cmp_true |=> $stable(result)) else $error("result changed");
    chk_cmp_false_flag: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        conv.done && compare_enable && !cmp_true && !wr_cc && !rd_rl |=> $stable(conv_done_flag))
        else $error("done flag changed on false compare");
    chk_result_load: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        accept |=> result == $past(conv.result)) else $error("result not loaded");
    chk_flag_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (wr_cc || rd_rl) && !accept |=> !conv_done_flag) else $error("done flag not cleared");
    // The enable that counts is the one standing after a write on the same edge
    chk_irq_raise: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        accept && (wr_cc ? i_pwdata[adccc_pkg::CC_IRQ_EN_BIT] : done_irq_enable) |=> o_done_irq)
        else $error("interrupt not raised");
    chk_irq_quiet: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        !done_irq_enable |-> !o_done_irq) else $error("interrupt while disabled");
    chk_single_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        conv.done && state == adccc_pkg::ADCCC_CONV && !wr_cc |=> !conv_active) else $error("no idle");
    // A later control write legally cuts the chain, so it ends the attempt
    chk_cont_repeat: assert property (@(posedge i_core_clk) disable iff (!i_arst_n || wr_cc)
        cont_done_s |=> ##[24:26] conv.done) else $error("no repeat");
    chk_cont_stays: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        cont_done_s |=> state == adccc_pkg::ADCCC_CONT) else $error("continuous mode dropped");
    chk_ref_result: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        conv.done && channel_select == adccc_pkg::CHAN_HIGH_REF |-> conv.result == 10'h3ff)
        else $error("high reference result wrong");
    chk_hw_start: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        hw_start |=> conv_active) else $error("hardware trigger ignored");
    chk_hw_mode_write: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        wr_cc && trigger_select && !conv_active |=> !conv_active) else $error("write started in hardware mode");
endmodule

// ---- sim/tb_adccc_top.sv ----
// Testbench of the conversion control block: APB traffic checked against a behavioural model
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD at %0t: mismatch got %h exp %h", $time, got, exp); end end
module tb_adccc_top;
    // ==========================================
    // Signals and model state
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic i_hw_trigger_in = 1'b0;
    logic [9:0] i_sample = 10'h000;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_converter_on, o_done_irq;
    logic [4:0] o_channel_select;
    logic [31:0] rd;
    logic last_err;
    logic [9:0] m_res;
    logic truth;
    int miscompares = 0;
    int tests_run = 0;
    adccc_top DUT (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_hw_trigger_in(i_hw_trigger_in), .i_sample(i_sample),
        .o_channel_select(o_channel_select), .o_converter_on(o_converter_on), .o_done_irq(o_done_irq));
    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end
    // ==========================================
    // Bus and check tasks
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= wdata;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        last_err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic chk_state(input logic flag, input logic [9:0] res, input logic irq, input logic cont);
        logic [1:0] hi;
        @(negedge i_core_clk);
        `CHK(o_done_irq, irq)
        apb(1'b0, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h0);
        `CHK(rd[adccc_pkg::CC_DONE_BIT], flag)
        apb(1'b0, adccc_pkg::ADDR_RESULT_HIGH, 32'h0);
        hi = rd[1:0];
        apb(1'b0, adccc_pkg::ADDR_RESULT_LOW, 32'h0);
        `CHK({hi, rd[7:0]}, res)
        if (!cont) begin
            apb(1'b0, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h0);
            `CHK(rd[adccc_pkg::CC_DONE_BIT], 1'b0)
        end
    endtask
    task automatic on_is(input logic v);
        @(negedge i_core_clk);
        `CHK(o_converter_on, v)
    endtask
    task automatic trig;
        @(posedge i_core_clk);
        i_hw_trigger_in <= 1'b1;
        @(posedge i_core_clk);
        i_hw_trigger_in <= 1'b0;
        repeat (2) @(posedge i_core_clk);
    endtask
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // Watchdog: the sequence needs about 800 cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        miscompares++;
        finish_test;
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(97));
        repeat (3) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        apb(1'b0, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h0);
        `CHK(rd[7:0], adccc_pkg::RST_CONVERSION_CONTROL)
        apb(1'b0, adccc_pkg::ADDR_COMPARE_TRIGGER_CONTROL, 32'h0);
        `CHK(rd[7:0], adccc_pkg::RST_COMPARE_TRIGGER_CONTROL)
        apb(1'b1, 8'h40, 32'h0);
        `CHK(last_err, 1'b1)
        on_is(1'b0);
        // Single conversions on an input and both references, interrupt on for one of them
        for (int i = 0; i < 3; i++) begin
            i_sample <= 10'($urandom());
            m_res = (i == 0) ? i_sample : ((i == 1) ? 10'h3ff : 10'h000);
            apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, {25'h0, (i == 1), 1'b0,
                (i == 0) ? 5'h03 : ((i == 1) ? adccc_pkg::CHAN_HIGH_REF : adccc_pkg::CHAN_LOW_REF)});
            m_res = (i == 0) ? i_sample : m_res;
            on_is(1'b1);
            `CHK(o_channel_select, (i == 0) ? 5'h03 : 5'h1c + 5'(i))
            apb(1'b0, adccc_pkg::ADDR_COMPARE_TRIGGER_CONTROL, 32'h0);
            `CHK(rd[adccc_pkg::CT_ACTIVE_BIT], 1'b1)
            repeat (30) @(posedge i_core_clk);
            on_is(1'b0);
            chk_state(1'b1, m_res, (i == 1), 1'b0);
        end
        // Abort by rewrite, then switch off with the all-ones channel
        apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h03);
        repeat (10) @(posedge i_core_clk);
        i_sample <= 10'($urandom());
        apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h03);
        m_res = i_sample;
        repeat (20) @(posedge i_core_clk);
        on_is(1'b1);
        repeat (10) @(posedge i_core_clk);
        apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h1f);
        repeat (30) @(posedge i_core_clk);
        on_is(1'b0);
        chk_state(1'b0, m_res, 1'b0, 1'b0);
        // Compare in both directions, true and false
        apb(1'b1, adccc_pkg::ADDR_COMPARE_LEVEL, 32'h200);
        for (int i = 0; i < 4; i++) begin
            i_sample <= i[0] ? 10'($urandom_range(511, 0)) : 10'($urandom_range(1023, 512));
            apb(1'b1, adccc_pkg::ADDR_COMPARE_TRIGGER_CONTROL, {26'h0, 1'b1, i[1], 4'h0});
            apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h03);
            truth = i[1] ? !i[0] : i[0];
            m_res = truth ? i_sample : m_res;
            repeat (30) @(posedge i_core_clk);
            chk_state(truth, m_res, 1'b0, 1'b0);
        end
        // Hardware trigger in single mode: write alone does not start
        apb(1'b1, adccc_pkg::ADDR_COMPARE_TRIGGER_CONTROL, 32'h40);
        i_sample <= 10'($urandom());
        apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h03);
        m_res = i_sample;
        on_is(1'b0);
        trig;
        on_is(1'b1);
        repeat (30) @(posedge i_core_clk);
        on_is(1'b0);
        chk_state(1'b1, m_res, 1'b0, 1'b0);
        // Continuous mode under both trigger sources, ended by the all-ones channel
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, adccc_pkg::ADDR_COMPARE_TRIGGER_CONTROL, {25'h0, t[0], 6'h0});
            apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h23);
            if (t == 1) begin
                trig;
            end
            repeat (60) @(posedge i_core_clk);
            i_sample <= 10'($urandom());
            on_is(1'b1);
            repeat (30) @(posedge i_core_clk);
            chk_state(1'b1, i_sample, 1'b0, 1'b1);
            apb(1'b1, adccc_pkg::ADDR_CONVERSION_CONTROL, 32'h3f);
            repeat (30) @(posedge i_core_clk);
            on_is(1'b0);
        end
        finish_test;
    end
endmodule
